// ==== sfr_pkg.sv ====
/*
 Package for the system interrupt enable and flag register bank.
 Assumes one 125 MHz clock and an AHB-Lite register bus, 32-bit words.
*/
package sfr_pkg;
  localparam int unsigned ADDR_W = 8;
  // Printed offsets are indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_ENABLE_1 = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_ENABLE_2 = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_FLAGS_1 = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_FLAGS_2 = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_WDT_MODE = 8'h06;
  // Enable register bits
  localparam int unsigned EN_WDT = 0;
  localparam int unsigned EN_OSC = 1;
  localparam int unsigned EN_NMI = 4;
  localparam int unsigned EN_ACCV = 5;
  localparam logic [7:0] EN_MASK = 8'h33;
  localparam logic [7:0] EN_RESET = 8'h00;
  // Flag register bits
  localparam int unsigned FL_WDT = 0;
  localparam int unsigned FL_OSC = 1;
  localparam int unsigned FL_POR = 2;
  localparam int unsigned FL_RST = 3;
  localparam int unsigned FL_NMI = 4;
  localparam logic [7:0] FL_MASK = 8'h1F;
  localparam logic [7:0] FL_POR_VALUE = 8'h06;
  localparam logic FL_OSC_SOFT = 1'b1;
  localparam logic FL_NMI_SOFT = 1'b0;
  // Interrupt status bits: one per request line
  localparam int unsigned ST_W = 4;
  localparam int unsigned ST_WDT = 0;
  localparam int unsigned ST_OSC = 1;
  localparam int unsigned ST_NMI = 2;
  localparam int unsigned ST_ACCV = 3;
  localparam logic [ST_W-1:0] ST_ZERO = 4'h0;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ==== sfr_sync_set.sv ====
/*
 Sticky bit with set-wins-over-clear priority.
 Assumes single clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module sfr_sync_set #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic set_i,
  input wire logic clr_i,
  output logic bit_q
);
  logic bit_d;
  assign bit_d = set_i ? 1'b1 : (clr_i ? 1'b0 : bit_q);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_q <= RST_VAL;
    end else begin
      bit_q <= bit_d;
    end
  end
endmodule
`default_nettype wire

// ==== sfr_bus_slave.sv ====
/*
 AHB-Lite slave front end: captures address phase, yields write strobe.
 Assumes single word transfers; always OKAY, zero wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module sfr_bus_slave (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_q,
  output logic rd_q,
  output logic [sfr_pkg::ADDR_W-1:0] idx_q
);
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= '0;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      idx_q <= haddr[sfr_pkg::ADDR_W+1:2];
    end
  end
endmodule
`default_nettype wire

// ==== sfr_regs.sv ====
/*
 System interrupt enable and flag register bank with AHB-Lite access.
 Assumes event inputs are one-cycle pulses synchronous to ref_clk;
 reset is the power-on reset level, soft_system_reset a soft reset pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module sfr_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic soft_system_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wdt_overflow,
  input wire logic wdt_interval_tick,
  input wire logic key_violation,
  input wire logic osc_fault,
  input wire logic pin_reset,
  input wire logic pin_nmi,
  input wire logic flash_violation,
  output logic watchdog_irq,
  output logic osc_fault_irq,
  output logic pin_nmi_irq,
  output logic flash_viol_irq,
  output logic irq
);
  logic wr, rd;
  logic [sfr_pkg::ADDR_W-1:0] idx;
  logic [7:0] en_q;
  logic [7:0] flags;
  logic wdt_interval_q;
  logic [sfr_pkg::ST_W-1:0] status_q, mask_q, status_d;
  logic [31:0] rdata_d;

  sfr_bus_slave u_bus (
    .ref_clk(ref_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_q(wr),
    .rd_q(rd),
    .idx_q(idx)
  );

  wire sel_en = idx == sfr_pkg::IDX_ENABLE_1;
  wire sel_fl = idx == sfr_pkg::IDX_FLAGS_1;
  wire sel_st = idx == sfr_pkg::IDX_IRQ_STATUS;
  wire sel_mk = idx == sfr_pkg::IDX_IRQ_MASK;
  wire sel_md = idx == sfr_pkg::IDX_WDT_MODE;
  wire wr_en = wr && sel_en;
  wire wr_fl = wr && sel_fl;
  wire [7:0] wd = hwdata[7:0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_q <= sfr_pkg::EN_RESET;
    end else if (soft_system_reset) begin
      en_q <= sfr_pkg::EN_RESET;
    end else if (wr_en) begin
      en_q <= wd & sfr_pkg::EN_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wdt_interval_q <= 1'b0;
      mask_q <= sfr_pkg::ST_ZERO;
    end else begin
      if (wr && sel_md) begin
        wdt_interval_q <= hwdata[0];
      end
      if (wr && sel_mk) begin
        mask_q <= hwdata[sfr_pkg::ST_W-1:0];
      end
    end
  end

  wire wdt_set = (wdt_overflow && !wdt_interval_q) || key_violation;
  sfr_sync_set #(.RST_VAL(1'b0)) u_fl_wdt (
    .ref_clk(ref_clk), .reset(reset),
    .set_i(wdt_set),
    .clr_i(pin_reset || (wr_fl && !wd[sfr_pkg::FL_WDT])),
    .bit_q(flags[sfr_pkg::FL_WDT])
  );
  // Oscillator flag set by fault or soft reset
  sfr_sync_set #(.RST_VAL(1'b1)) u_fl_osc (
    .ref_clk(ref_clk), .reset(reset),
    .set_i(osc_fault || (soft_system_reset && sfr_pkg::FL_OSC_SOFT)),
    .clr_i(wr_fl && !wd[sfr_pkg::FL_OSC]),
    .bit_q(flags[sfr_pkg::FL_OSC])
  );
  // Power-on flag kept over soft reset
  sfr_sync_set #(.RST_VAL(1'b1)) u_fl_por (
    .ref_clk(ref_clk), .reset(reset),
    .set_i(wr_fl && wd[sfr_pkg::FL_POR]),
    .clr_i(wr_fl && !wd[sfr_pkg::FL_POR]),
    .bit_q(flags[sfr_pkg::FL_POR])
  );
  sfr_sync_set #(.RST_VAL(1'b0)) u_fl_rst (
    .ref_clk(ref_clk), .reset(reset),
    .set_i(pin_reset || (wr_fl && wd[sfr_pkg::FL_RST])),
    .clr_i(wr_fl && !wd[sfr_pkg::FL_RST]),
    .bit_q(flags[sfr_pkg::FL_RST])
  );
  // Pin event flag, soft reset clears
  sfr_sync_set #(.RST_VAL(1'b0)) u_fl_nmi (
    .ref_clk(ref_clk), .reset(reset),
    .set_i(pin_nmi || (wr_fl && wd[sfr_pkg::FL_NMI])),
    .clr_i((soft_system_reset && !sfr_pkg::FL_NMI_SOFT) ||
           (wr_fl && !wd[sfr_pkg::FL_NMI])),
    .bit_q(flags[sfr_pkg::FL_NMI])
  );
  assign flags[7:5] = 3'h0;

  // Watchdog request only in interval mode
  wire wdt_req = wdt_interval_q && wdt_interval_tick &&
                 en_q[sfr_pkg::EN_WDT];
  // Individual enables gate requests
  // Requests follow the event, so a read-clear of status is not refilled
  wire osc_req = osc_fault && en_q[sfr_pkg::EN_OSC];
  wire nmi_req = pin_nmi && en_q[sfr_pkg::EN_NMI];
  wire accv_req = flash_violation && en_q[sfr_pkg::EN_ACCV];

  wire [sfr_pkg::ST_W-1:0] ev = {accv_req, nmi_req, osc_req, wdt_req};
  wire st_clr = rd && sel_st;
  // Set wins over read-clear
  assign status_d = ev | (st_clr ? sfr_pkg::ST_ZERO : status_q);

  // Unmapped and second registers read zero
  assign rdata_d = sel_en ? {24'h000000, en_q} :
                   sel_fl ? {24'h000000, flags} :
                   sel_st ? {28'h0000000, status_q} :
                   sel_mk ? {28'h0000000, mask_q} :
                   sel_md ? {31'h00000000, wdt_interval_q} : 32'h00000000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_q <= sfr_pkg::ST_ZERO;
      watchdog_irq <= 1'b0;
      osc_fault_irq <= 1'b0;
      pin_nmi_irq <= 1'b0;
      flash_viol_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      status_q <= status_d;
      watchdog_irq <= wdt_req;
      osc_fault_irq <= osc_req;
      pin_nmi_irq <= nmi_req;
      flash_viol_irq <= accv_req;
      irq <= |(status_d & mask_q);
    end
  end

  // Read data registered off the address phase
  wire take_rd = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= take_rd ? rdata_read(haddr) : 32'h00000000;
    end
  end

  function automatic logic [31:0] rdata_read(input logic [31:0] a);
    logic [sfr_pkg::ADDR_W-1:0] i;
    i = a[sfr_pkg::ADDR_W+1:2];
    case (i)
      sfr_pkg::IDX_ENABLE_1: rdata_read = {24'h000000, en_q};
      sfr_pkg::IDX_FLAGS_1: rdata_read = {24'h000000, flags};
      sfr_pkg::IDX_IRQ_STATUS: rdata_read = {28'h0000000, status_q};
      sfr_pkg::IDX_IRQ_MASK: rdata_read = {28'h0000000, mask_q};
      sfr_pkg::IDX_WDT_MODE: rdata_read = {31'h00000000, wdt_interval_q};
      default: rdata_read = 32'h00000000;
    endcase
  endfunction

  // Flash enable cleared after soft reset
  soft_clears_a: assert property (@(posedge ref_clk) disable iff (reset)
    soft_system_reset |=> !en_q[sfr_pkg::EN_ACCV])
    else $error("flash enable not cleared");
  // Watchdog request blocked in reset mode
  wdt_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    !wdt_interval_q |=> !watchdog_irq)
    else $error("watchdog request in reset mode");
  wdt_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    (key_violation && !pin_reset) |=> flags[sfr_pkg::FL_WDT])
    else $error("watchdog flag not set");
  wdt_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    (pin_reset && !wdt_set) |=> !flags[sfr_pkg::FL_WDT])
    else $error("watchdog flag not cleared");
  rst_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    pin_reset |=> flags[sfr_pkg::FL_RST])
    else $error("pin reset flag not set");
  // Soft reset clears pin event flag
  nmi_soft_a: assert property (@(posedge ref_clk) disable iff (reset)
    (soft_system_reset && !pin_nmi) |=> !flags[sfr_pkg::FL_NMI])
    else $error("pin event flag not cleared");
  // Power-on flag kept over soft reset
  por_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    (soft_system_reset && !wr_fl) |=> $stable(flags[sfr_pkg::FL_POR]))
    else $error("power-on flag lost");
  osc_soft_a: assert property (@(posedge ref_clk) disable iff (reset)
    soft_system_reset |=> flags[sfr_pkg::FL_OSC])
    else $error("oscillator flag not set");
  osc_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    !en_q[sfr_pkg::EN_OSC] |=> !osc_fault_irq)
    else $error("oscillator request not blocked");
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    (take_rd && haddr[sfr_pkg::ADDR_W+1:2] == sfr_pkg::IDX_FLAGS_2)
    |=> hrdata == 32'h00000000)
    else $error("reserved register not zero");
  en_bits_a: assert property (@(posedge ref_clk) disable iff (reset)
    (en_q & ~sfr_pkg::EN_MASK) == 8'h00)
    else $error("unused enable bit stored");

  irq_seen_c: cover property (@(posedge ref_clk) disable iff (reset) irq);
  wdt_seen_c: cover property (@(posedge ref_clk) disable iff (reset)
    watchdog_irq);
  soft_seen_c: cover property (@(posedge ref_clk) disable iff (reset)
    soft_system_reset ##1 wr_en);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench for the system interrupt enable and flag bank.
 Assumes sfr_regs as top, zero-wait AHB-Lite slave, one 125 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk, reset, soft_system_reset, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hreadyout, hresp, irq;
  logic [6:0] ev;
  logic [3:0] irq_vec;
  int mismatches, cmp_count;
  int en, fl, st, mk, md;
  logic [15:0] rnd;
  sfr_regs i_sfr_regs (.ref_clk(ref_clk), .reset(reset),
    .soft_system_reset(soft_system_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(sfr_pkg::HSIZE_WORD), .hwrite(hwrite),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wdt_overflow(ev[0]),
    .wdt_interval_tick(ev[1]), .key_violation(ev[2]), .osc_fault(ev[3]),
    .pin_reset(ev[4]), .pin_nmi(ev[5]), .flash_violation(ev[6]),
    .watchdog_irq(irq_vec[0]), .osc_fault_irq(irq_vec[1]),
    .pin_nmi_irq(irq_vec[2]), .flash_viol_irq(irq_vec[3]), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One single transfer, waiting on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= sfr_pkg::HTRANS_NONSEQ;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input int a, input int d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    case (a)
      0: en = d & 'h33;
      8: fl = (fl & d & 'h1F) | (d & 'h1C);
      'h14: mk = d & 'hF;
      'h18: md = d & 1;
      default: ;
    endcase
  endtask
  task automatic rd(input int a);
    logic [31:0] q;
    int e;
    case (a)
      0: e = en;
      8: e = fl;
      'h10: e = st;
      'h14: e = mk;
      'h18: e = md;
      default: e = 0;
    endcase
    bus(1'b0, a, 32'h0, q);
    chk("read data", q, e);
    if (a == 'h10) st = 0;
  endtask
  // Pulse one event and check the request lines one cycle later
  task automatic pulse(input int b);
    int x;
    @(posedge ref_clk);
    ev <= 7'h01 << b;
    @(posedge ref_clk);
    ev <= 7'h00;
    if (b == 0 && md == 0) fl = fl | 1;
    if (b == 2) fl = fl | 1;
    if (b == 3) fl = fl | 2;
    if (b == 4) fl = (fl | 8) & ~1;
    if (b == 5) fl = fl | 'h10;
    x = 0;
    if (b == 1 && md == 1 && en[0]) x = 1;
    if (b == 3 && en[1]) x = 2;
    if (b == 5 && en[4]) x = 4;
    if (b == 6 && en[5]) x = 8;
    st = st | x;
    #1;
    chk("request lines", {28'h0, irq_vec}, x);
  endtask
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    soft_system_reset = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    ev = 7'h00;
    en = 0; fl = 'h06; st = 0; mk = 0; md = 0;
    rnd = 16'h5E66;
    mismatches = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Power-on values and unmapped places
    for (int i = 0; i < 8; i++) rd(i * 4);
    // Random writes everywhere except the read-clear status
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        if (i != 4) wr(i * 4, {rnd, lfsr(rnd)});
      end
      for (int i = 0; i < 8; i++) rd(i * 4);
    end
    // Every event with enables on and off, both watchdog modes, except wdt_overflow in interval mode
    wr('h14, 'hF);
    for (int e = 0; e < 2; e++) begin
      wr(0, e == 0 ? 'hFF : 'h00);
      for (int m = 0; m < 2; m++) begin
        wr('h18, m);
        rd('h10);
        for (int b = 0; b < 7; b++) if (!(b == 0 && m == 1)) pulse(b);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, {31'h0, (st & mk) != 0});
        rd(8);
        rd('h10);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
      end
    end
    // Soft reset keeps power-on bits and loads the others
    wr(8, 'h1C);
    wr(0, 'h33);
    rd(0);
    soft_system_reset <= 1'b1;
    @(posedge ref_clk);
    soft_system_reset <= 1'b0;
    en = 0;
    fl = (fl | 2) & ~'h10;
    @(posedge ref_clk);
    rd(0);
    rd(8);
    test_done();
  end
endmodule
`default_nettype wire
